// ### src/hps_pkg.sv
// Purpose: Shared constants and types for the host port handshake block
// Assumes: Core clock of 10 MHz; host side is asynchronous
// Notes:   Host register select codes and status bit positions live here
package hps_pkg;

	// ****************************************
	// Host register select codes
	// ****************************************
	localparam logic [2:0] HPS_SEL_CTRL   = 3'h0;
	localparam logic [2:0] HPS_SEL_VECTOR = 3'h1;
	localparam logic [2:0] HPS_SEL_STATUS = 3'h2;
	localparam logic [2:0] HPS_SEL_RSVD   = 3'h3;
	localparam logic [2:0] HPS_SEL_XHIGH  = 3'h6;
	localparam logic [2:0] HPS_SEL_XLOW   = 3'h7;

	// ****************************************
	// Status byte field positions
	// ****************************************
	localparam int HPS_ST_RXF  = 0;
	localparam int HPS_ST_TXE  = 1;
	localparam int HPS_ST_TRANSMITTER_READY_BIT = 2;
	localparam int HPS_ST_F2   = 3;
	localparam int HPS_ST_F3   = 4;
	localparam int HPS_ST_DMA  = 6;
	localparam int HPS_ST_REQ  = 7;

	// Control byte field positions
	localparam int HPS_CT_F0   = 3;
	localparam int HPS_CT_F1   = 4;
	localparam int HPS_CT_DMA  = 6;

	// Vector byte: command bit on top, vector below
	localparam int HPS_CV_CMD  = 7;
	localparam int HPS_VEC_W   = 6;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0]  HPS_BYTE_RST   = 8'h00;
	localparam logic [15:0] HPS_WORD_RST   = 16'h0000;
	localparam int          HPS_CLK_HZ     = 10000000;
	localparam int          HPS_SYNC_STAGES = 2;
	// Settle gap between a strobe edge and the core acting on it
	localparam int          HPS_SETTLE_CYC = 1;

	typedef enum logic [1:0] {
		HPS_IDLE,
		HPS_ACCESS,
		HPS_FINISH
	} hps_acc_e;

endpackage

// ### src/hps_port.sv
// Purpose: Byte-wide asynchronous host port with flag handshakes
// Assumes: Host strobes are asynchronous; core logic on clk_sys
// Notes:   Host accesses are decoded on the synchronised strobe assertion; writes land after release
//
// Summary of operation
// - Transmit bytes move into core receive word
// - Core sets and clears host-visible status
// - Status stable for long enough strobes
// - Command may be withdrawn, may still run
// - Host-side bits synchronised one by one
// - Core double-reads host flag pair
// - Host inputs synchronised within three quarters
`timescale 1ns/1ps
module hps_port (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        port_enable_strobe_n,
	input  wire logic        dma_acknowledge_strobe_n,
	input  wire logic        port_direction_line,
	input  wire logic [2:0]  port_register_select,
	input  wire logic [7:0]  host_data_in,
	output logic      [7:0]  host_data_out,
	output logic             host_data_oe,
	output logic             host_request_line_n,
	output logic             host_request_line_oe,
	input  wire logic        core_rx_read,
	output logic      [15:0] core_receive_word,
	output logic             core_rx_full,
	input  wire logic        core_tx_write,
	input  wire logic [15:0] core_tx_word,
	output logic             core_tx_empty,
	input  wire logic        core_flag_b3,
	input  wire logic        core_flag_b2,
	input  wire logic        core_dma_mode,
	input  wire logic        core_command_ack,
	output logic             core_command_pending,
	output logic      [5:0]  command_vector_bits,
	output logic             host_flag_b1,
	output logic             host_flag_b0,
	output logic             core_host_dma
);
	import hps_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		hps_acc_e    acc;
		logic        rd;
		logic [2:0]  sel;
		logic [7:0]  wdata;
		logic [7:0]  tx_hi;
		logic [7:0]  tx_lo;
		logic        tx_empty_flag;
		logic [15:0] rx_word;
		logic        rx_word_full;
		logic [7:0]  rx_byte_high;
		logic [7:0]  rx_byte_low;
		logic        rx_full_flag;
		logic        cmd;
		logic [5:0]  vec;
		logic        f1;
		logic        f0;
		logic        dma;
		logic [7:0]  dout;
		logic        oe;
		logic [7:0]  din_meta;
		logic [7:0]  din_stab;
	} hps_state_s;

	hps_state_s s_q;
	hps_state_s s_d;

	hps_sync_if sif ();

	logic strobe;
	logic [7:0] status_byte;

	// ****************************************
	// Input synchronisation
	// ****************************************
	// two-stage sampling
	assign sif.raw = {port_direction_line, port_register_select, 1'b0,
		~dma_acknowledge_strobe_n, ~port_enable_strobe_n, 1'b0};

	hps_sync u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.sif     (sif)
	);

	assign strobe = sif.synced[1] | (s_q.dma & sif.synced[2]);

	function automatic logic is_sel(input logic [2:0] a, input logic [2:0] b);
		return a == b;
	endfunction

	always_comb begin
		status_byte              = HPS_BYTE_RST;
		status_byte[HPS_ST_RXF]  = s_q.rx_full_flag;
		status_byte[HPS_ST_TXE]  = s_q.tx_empty_flag;
		status_byte[HPS_ST_TRANSMITTER_READY_BIT] = s_q.tx_empty_flag & ~s_q.rx_word_full;
		status_byte[HPS_ST_F2]   = core_flag_b2;
		status_byte[HPS_ST_F3]   = core_flag_b3;
		status_byte[HPS_ST_DMA]  = s_q.dma;
		status_byte[HPS_ST_REQ]  = s_q.dma ? (s_q.rx_full_flag | s_q.tx_empty_flag)
			: (s_q.rx_full_flag | s_q.tx_empty_flag);
	end

	// ****************************************
	// Access sequencing
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.din_meta = host_data_in;
		s_d.din_stab = s_q.din_meta;
		case (s_q.acc)
			HPS_IDLE: begin
				if (strobe) begin
					s_d.acc = HPS_ACCESS;
					s_d.rd  = sif.synced[7];
					s_d.sel = sif.synced[6:4];
					s_d.oe  = sif.synced[7];
					case (sif.synced[6:4])
						HPS_SEL_STATUS: s_d.dout = status_byte;
						HPS_SEL_VECTOR: s_d.dout = {s_q.cmd, 1'b0, s_q.vec};
						HPS_SEL_CTRL:   s_d.dout = {1'b0, s_q.dma, 1'b0, s_q.f1,
							s_q.f0, 3'h0};
						HPS_SEL_XHIGH:  s_d.dout = s_q.rx_byte_high;
						HPS_SEL_XLOW:   s_d.dout = s_q.rx_byte_low;
						default:        s_d.dout = HPS_BYTE_RST;
					endcase
				end
			end
			HPS_ACCESS: begin
				s_d.wdata = s_q.din_stab;
				if (!strobe) begin
					s_d.acc = HPS_FINISH;
					s_d.oe  = 1'b0;
				end
			end
			HPS_FINISH: begin
				s_d.acc = HPS_IDLE;
				if (!s_q.rd) begin
					case (s_q.sel)
						HPS_SEL_CTRL: begin
							s_d.f0  = s_q.wdata[HPS_CT_F0];
							s_d.f1  = s_q.wdata[HPS_CT_F1];
							s_d.dma = s_q.wdata[HPS_CT_DMA];
						end
						HPS_SEL_VECTOR: begin
							s_d.cmd = s_q.wdata[HPS_CV_CMD];
							s_d.vec = s_q.wdata[HPS_VEC_W-1:0];
						end
						HPS_SEL_XHIGH: s_d.tx_hi = s_q.wdata;
						HPS_SEL_XLOW: begin
							s_d.tx_lo         = s_q.wdata;
							s_d.tx_empty_flag = 1'b0;
						end
						default: s_d = s_d;
					endcase
				end else if (is_sel(s_q.sel, HPS_SEL_XLOW)) begin
					s_d.rx_full_flag = 1'b0;
				end
			end
			default: s_d.acc = HPS_IDLE;
		endcase

		if (!s_q.tx_empty_flag && !s_q.rx_word_full) begin
			s_d.rx_word       = {s_q.tx_hi, s_q.tx_lo};
			s_d.rx_word_full  = 1'b1;
			s_d.tx_empty_flag = 1'b1;
		end
		if (core_rx_read && s_q.rx_word_full) begin
			s_d.rx_word_full = 1'b0;
		end
		if (core_tx_write && !s_q.rx_full_flag) begin
			s_d.rx_byte_high = core_tx_word[15:8];
			s_d.rx_byte_low  = core_tx_word[7:0];
			s_d.rx_full_flag = 1'b1;
		end
		// Host set beats core acknowledge clear: acknowledge only drops a live command
		if (core_command_ack && s_q.cmd && !(s_d.cmd && s_q.acc == HPS_FINISH)) begin
			s_d.cmd = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_q               <= '0;
			s_q.acc           <= HPS_IDLE;
			s_q.tx_empty_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign host_data_out        = s_q.dout;
	assign host_data_oe         = s_q.oe;
	assign host_request_line_n  = 1'b0;
	assign host_request_line_oe = status_byte[HPS_ST_REQ] & ~core_dma_mode;
	assign core_receive_word    = s_q.rx_word;
	assign core_rx_full         = s_q.rx_word_full;
	assign core_tx_empty        = ~s_q.rx_full_flag;
	assign host_flag_b1         = s_q.f1;
	assign host_flag_b0         = s_q.f0;
	assign core_command_pending = s_q.cmd;
	assign command_vector_bits  = s_q.vec;
	assign core_host_dma        = s_q.dma;

endmodule // hps_port

// ### src/hps_sync.sv
// Purpose: Per-bit two-stage synchroniser bank
// Assumes: Inputs are asynchronous levels
// Notes:   Each bit is resolved alone; no group coherence is implied
`timescale 1ns/1ps
module hps_sync (
	input wire logic clk_sys,
	input wire logic reset_n,
	hps_sync_if.snk  sif
);
	import hps_pkg::*;

	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] stab;
	} hps_sync_s;

	hps_sync_s st_q;
	hps_sync_s st_d;

	// ****************************************
	// Synchroniser stages
	// ****************************************
	// per-bit synchronisation
	always_comb begin
		st_d      = st_q;
		st_d.meta = sif.raw;
		st_d.stab = st_q.meta;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sif.synced = st_q.stab;

endmodule // hps_sync

// ### src/hps_sync_if.sv
// Purpose: Bundle of raw asynchronous host levels and their synchronised copies
// Assumes: One core clock
// Notes:   Carries levels between the top module and the synchroniser bank
`timescale 1ns/1ps
interface hps_sync_if;
	logic [7:0] raw;
	logic [7:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface

// ### verification/host_port_handshake_sync_bench.sv
// Purpose: Self-checking bench for hps_port
// Assumes: Inputs change on falling edges
// Notes:   DMA acknowledge is driven by the bench, only in the DMA scenario
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module host_port_handshake_sync_bench;
	import hps_pkg::*;
	logic		clk_sys, reset_n, port_enable_strobe_n, dma_acknowledge_strobe_n;
	logic		port_direction_line, host_data_oe, host_request_line_n, host_request_line_oe;
	logic		core_rx_read, core_rx_full, core_tx_write, core_tx_empty, core_flag_b3;
	logic		core_flag_b2, core_dma_mode, core_command_ack, core_command_pending;
	logic		host_flag_b1, host_flag_b0, core_host_dma;
	logic [2:0]	port_register_select;
	logic [5:0]	command_vector_bits;
	logic [7:0]	host_data_in, host_data_out, s;
	logic [15:0]	core_receive_word, core_tx_word, r;
	int		err_count = 0;
	int		cmp_count = 0;
	hps_port u_dut (.*);
	hps_host_model u_host (.*);
	task automatic close_out();
		$display("cmp_count=%0d err_count=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic t_reset();
		u_host.acc(1'b1, HPS_SEL_STATUS, 8'h00, s);
		`CHK(s[HPS_ST_TXE:HPS_ST_RXF], 2'b10)
		`CHK({core_tx_empty, core_rx_full, core_command_pending}, 3'b100)
		u_host.acc(1'b1, HPS_SEL_RSVD, 8'h00, s);
		`CHK(s, 8'h00)
		`CHK({host_request_line_oe, host_request_line_n}, 2'b10)
		core_dma_mode <= 1'b1;
		idle(2);
		`CHK(host_request_line_oe, 1'b0)
		core_dma_mode <= 1'b0;
	endtask
	task automatic t_xfer();
		u_host.wr_tx(16'hC35A);
		for (int i = 0; i < 20 && !core_rx_full; i++) idle(1);
		`CHK(core_receive_word, 16'hC35A)
		core_rx_read <= 1'b1;
		idle(1);
		core_rx_read <= 1'b0;
		idle(1);
		`CHK(core_rx_full, 1'b0)
	endtask
	task automatic t_to_host();
		core_tx_word <= 16'h3CA5;
		core_tx_write <= 1'b1;
		idle(1);
		core_tx_word <= 16'h1111;
		idle(1);
		core_tx_write <= 1'b0;
		`CHK(core_tx_empty, 1'b0)
		u_host.rd_rx(r);
		idle(4);
		`CHK({r, core_tx_empty}, {16'h3CA5, 1'b1})
	endtask
	task automatic t_flags();
		u_host.acc(1'b0, HPS_SEL_CTRL, 8'h50, s);
		idle(4);
		`CHK({core_host_dma, host_flag_b1, host_flag_b0}, 3'b110)
		`CHK({host_flag_b1, host_flag_b0}, 2'b10)
		core_flag_b3 <= 1'b1;
		core_flag_b2 <= 1'b1;
		repeat (2) begin
			u_host.acc(1'b1, HPS_SEL_STATUS, 8'h00, s);
			`CHK(s[HPS_ST_F3:HPS_ST_F2], 2'b11)
		end
		// Acknowledge strobe stands in for enable while DMA is set
		dma_acknowledge_strobe_n <= 1'b0;
		idle(4);
		`CHK({host_data_oe, host_data_out}, 9'h1DE)
		dma_acknowledge_strobe_n <= 1'b1;
		idle(5);
		`CHK(host_data_oe, 1'b0)
		u_host.acc(1'b0, HPS_SEL_CTRL, 8'h08, s);
		idle(4);
		`CHK({core_host_dma, host_flag_b1, host_flag_b0}, 3'b001)
	endtask
	task automatic t_cmd();
		u_host.acc(1'b0, HPS_SEL_VECTOR, 8'hAB, s);
		idle(4);
		`CHK({core_command_pending, command_vector_bits}, 7'h6B)
		core_command_ack <= 1'b1;
		idle(1);
		core_command_ack <= 1'b0;
		idle(1);
		`CHK(core_command_pending, 1'b0)
		u_host.acc(1'b0, HPS_SEL_VECTOR, 8'hAB, s);
		u_host.acc(1'b0, HPS_SEL_VECTOR, 8'h2B, s);
		idle(4);
		`CHK({core_command_pending, command_vector_bits}, 7'h2B)
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#1ms;
		err_count++;
		close_out();
	end
	initial begin
		{reset_n, core_rx_read, core_tx_write, core_flag_b3, core_flag_b2} = '0;
		{core_dma_mode, core_command_ack, core_tx_word} = '0;
		dma_acknowledge_strobe_n = 1'b1;
		idle(10);
		reset_n = 1'b1;
		t_reset();
		t_xfer();
		t_to_host();
		t_flags();
		t_cmd();
		close_out();
	end
endmodule // host_port_handshake_sync_bench

// ### verification/hps_host_model.sv
// Purpose: Host processor model on the host port pins
// Assumes: Pins change on falling edges
// Notes:   Released data lines show the inverse byte
`timescale 1ns/1ps
module hps_host_model (
	input wire logic	clk_sys,
	input wire logic [7:0]	host_data_out,
	output logic		port_enable_strobe_n,
	output logic		port_direction_line,
	output logic [2:0]	port_register_select,
	output logic [7:0]	host_data_in
);
	import hps_pkg::*;
	initial begin
		port_enable_strobe_n = 1'b1;
		port_direction_line = 1'b1;
		port_register_select = 3'h0;
		host_data_in = 8'h5A;
	end
	task automatic acc(input logic rd, input logic [2:0] s, input logic [7:0] w,
			output logic [7:0] r);
		port_direction_line <= rd;
		port_register_select <= s;
		host_data_in <= w;
		@(negedge clk_sys) port_enable_strobe_n <= 1'b0;
		repeat (4) @(negedge clk_sys);
		r = host_data_out;
		port_enable_strobe_n <= 1'b1;
		repeat (3) @(negedge clk_sys);
		host_data_in <= ~w;
		repeat (2) @(negedge clk_sys);
	endtask
	task automatic wr_tx(input logic [15:0] v);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 20 && !s[HPS_ST_TXE]; i++) acc(1'b1, HPS_SEL_STATUS, 8'h00, s);
		acc(1'b0, HPS_SEL_XHIGH, v[15:8], s);
		acc(1'b0, HPS_SEL_XLOW, v[7:0], s);
	endtask
	task automatic rd_rx(output logic [15:0] v);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 20 && !s[HPS_ST_RXF]; i++) acc(1'b1, HPS_SEL_STATUS, 8'h00, s);
		acc(1'b1, HPS_SEL_XHIGH, 8'h00, v[15:8]);
		acc(1'b1, HPS_SEL_XLOW, 8'h00, v[7:0]);
	endtask
endmodule // hps_host_model

// ### verification/hps_port_props.sv
// Purpose: Port assertions for hps_port
// Assumes: One core clock, async low reset
// Notes:   idle_q counts cycles since the last strobe
`timescale 1ns/1ps
module hps_port_props (
	input wire logic	clk_sys,
	input wire logic	reset_n,
	input wire logic	port_enable_strobe_n,
	input wire logic	dma_acknowledge_strobe_n,
	input wire logic [7:0]	host_data_out,
	input wire logic	host_data_oe,
	input wire logic	host_request_line_oe,
	input wire logic	core_rx_read,
	input wire logic [15:0]	core_receive_word,
	input wire logic	core_rx_full,
	input wire logic	core_tx_empty,
	input wire logic	core_dma_mode,
	input wire logic [5:0]	command_vector_bits,
	input wire logic	host_flag_b1,
	input wire logic	host_flag_b0,
	input wire logic	core_host_dma
);
	logic [3:0]	idle_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			idle_q <= 4'h0;
		else if (!port_enable_strobe_n || !dma_acknowledge_strobe_n)
			idle_q <= 4'h0;
		else if (idle_q != 4'hF)
			idle_q <= idle_q + 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_oe_cause: assert property (
		$rose(host_data_oe) |-> !$past(port_enable_strobe_n, 2)
		|| !$past(dma_acknowledge_strobe_n, 2)) else $error("data before sync");
	a_oe_release: assert property (
		$rose(port_enable_strobe_n) && dma_acknowledge_strobe_n |-> ##[1:5] !host_data_oe)
		else $error("data held too long");
	a_out_stable: assert property (
		host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
		else $error("read data moved");
	a_word_cause: assert property (
		!$stable(core_receive_word) |-> $rose(core_rx_full)) else $error("stray word");
	a_rx_consume: assert property (
		core_rx_full && core_rx_read |=> !core_rx_full) else $error("full not cleared");
	a_bits_quiet: assert property (
		idle_q > 4'h8 |-> $stable({host_flag_b1, host_flag_b0, command_vector_bits,
		core_host_dma})) else $error("host bits moved");
	a_idle_no_oe: assert property (
		idle_q > 4'h6 |-> !host_data_oe) else $error("data with no strobe");
	a_req_dma: assert property (
		core_dma_mode |-> !host_request_line_oe) else $error("request in dma mode");
	a_req_rxfull: assert property (
		!core_dma_mode && !core_tx_empty |-> host_request_line_oe)
		else $error("no request with receive bytes full");
	c_read: cover property ($rose(host_data_oe));
	c_xfer: cover property ($rose(core_rx_full));
	c_dma: cover property (core_dma_mode);
	c_dack: cover property (!dma_acknowledge_strobe_n && core_host_dma && host_data_oe);
endmodule // hps_port_props
bind hps_port hps_port_props u_props (.*);
